// >>> uabs_baud_addr.sv
// baud clock selection, two internal baud generators, slave address
// and mask registers, framing error flag for two uarts
// assumes a classic wishbone master on clk and same-clock timer and
// receiver logic driving the pulse inputs
//
// Summary of operation
// - uart0 tx clock: generator if tx select, else timer2 if t2 tx select, else timer1
// - uart0 rx clock chosen alike but independently, with its own select bits
// - uart1 uses same selection with own generator bits, shares timer2 selects
// - two identical internal baud generators, one per uart
// - generator tick comes from overflow; reload, speed and doubling set it
// - rate = 2^dbl * clk / (6^(1-speed) * 32 * (256 - reload))
// - invalid stop bit sets framing error flag, serial control bit 7
// - framing error stays set until software clears it; valid stops never clear
// - bit 7 reaches framing error when access bit set, else mode bit zero
// - slave address and mask registers are 8 bits, reset to zero
// - given address matches where mask bits are one
// - broadcast address is address OR mask, zero bits are don't care
`timescale 1ns/100ps
`include "uabs_defs.svh"

module uabs_baud_addr (
    input  wire logic        clk,          // 50 MHz clock
    input  wire logic        arst_n,       // async reset, active low
    input  wire logic        cyc_i,        // wishbone cycle
    input  wire logic        stb_i,        // wishbone strobe
    input  wire logic        we_i,         // wishbone write
    input  wire logic [31:0] adr_i,        // wishbone byte address
    input  wire logic [3:0]  sel_i,        // wishbone byte lanes
    input  wire logic [31:0] dat_i,        // wishbone write data
    output logic      [31:0] dat_o,        // wishbone read data
    output logic             ack_o,        // wishbone acknowledge
    input  wire logic        timer1Ovf,    // timer 1 baud pulse
    input  wire logic        timer2Ovf,    // timer 2 baud pulse
    input  wire logic        rxStopBad0,   // uart0 frame with bad stop
    input  wire logic        rxStopBad1,   // uart1 frame with bad stop
    input  wire logic [7:0]  rxAddr0,      // uart0 received address
    input  wire logic [7:0]  rxAddr1,      // uart1 received address
    output logic             addrMatch0,   // uart0 given or broadcast hit
    output logic             addrMatch1,   // uart1 given or broadcast hit
    output logic             txTick0,      // uart0 transmit baud tick
    output logic             rxTick0,      // uart0 receive baud tick
    output logic             txTick1,      // uart1 transmit baud tick
    output logic             rxTick1,      // uart1 receive baud tick
    output logic             modeBitZero0, // uart0 mode bit zero
    output logic             modeBitZero1, // uart1 mode bit zero
    output logic             framingErr0,  // uart0 framing error flag
    output logic             framingErr1   // uart1 framing error flag
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic pickTick(input logic genSel, input logic t2Sel,
                                      input logic gen, input logic t1,
                                      input logic t2);
        pickTick = genSel ? gen : (t2Sel ? t2 : t1);
    endfunction : pickTick

    function automatic logic addrHit(input uabs_pkg::uabs_byte_t rx,
                                     input uabs_pkg::uabs_byte_t sa,
                                     input uabs_pkg::uabs_byte_t mk);
        logic given;
        logic bcast;
        given   = (((rx ^ sa) & mk) == 8'h00);
        bcast   = ((rx | ~(sa | mk)) == 8'hff);
        addrHit = given | bcast;
    endfunction : addrHit

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic [1:0] rstSync_q;
    logic [1:0] rstSync_d;
    logic       rst_n;

    always_comb begin
        rstSync_d = {rstSync_q[0], 1'b1};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= rstSync_d;
        end
    end

    assign rst_n = rstSync_q[1];

    // ------------------------------------------------------------------
    // register file and bus slave
    // ------------------------------------------------------------------
    uabs_pkg::uabs_byte_t sladr_q  [2];
    uabs_pkg::uabs_byte_t sladr_d  [2];
    uabs_pkg::uabs_byte_t smask_q  [2];
    uabs_pkg::uabs_byte_t smask_d  [2];
    uabs_pkg::uabs_byte_t gctl_q   [2];
    uabs_pkg::uabs_byte_t gctl_d   [2];
    uabs_pkg::uabs_byte_t reload_q [2];
    uabs_pkg::uabs_byte_t reload_d [2];
    logic [6:0]           sclow_q  [2];
    logic [6:0]           sclow_d  [2];
    uabs_pkg::uabs_pair_t err_q;
    uabs_pkg::uabs_pair_t err_d;
    uabs_pkg::uabs_pair_t mbz_q;
    uabs_pkg::uabs_pair_t mbz_d;
    uabs_pkg::uabs_byte_t t2ctl_q;
    uabs_pkg::uabs_byte_t t2ctl_d;
    uabs_pkg::uabs_byte_t pwr_q;
    uabs_pkg::uabs_byte_t pwr_d;
    logic                 ack_q;
    logic                 ack_d;
    logic [31:0]          rdat_q;
    logic [31:0]          rdat_d;
    logic                 req;
    logic                 mapped;
    logic                 wrEn;
    logic [7:0]           idx;
    uabs_pkg::uabs_pair_t stopBad;
    uabs_pkg::uabs_pair_t access;
    uabs_pkg::uabs_byte_t rdByte;
    logic                 scSel;

    assign idx     = adr_i[9:2];
    assign scSel   = (idx == `UABS_IDX_SCTL1);
    assign req     = cyc_i & stb_i & ~ack_q;
    assign wrEn    = req & we_i & sel_i[0];
    assign stopBad = {rxStopBad1, rxStopBad0};
    assign access  = {pwr_q[`UABS_PC_ACC1_BIT], pwr_q[`UABS_PC_ACC0_BIT]};

    always_comb begin
        sladr_d  = sladr_q;
        smask_d  = smask_q;
        gctl_d   = gctl_q;
        reload_d = reload_q;
        sclow_d  = sclow_q;
        err_d    = err_q;
        mbz_d    = mbz_q;
        t2ctl_d  = t2ctl_q;
        pwr_d    = pwr_q;
        rdByte   = 8'h00;
        mapped   = (adr_i[31:10] == 22'h00_0000);
        unique case (idx)
            `UABS_IDX_SCTL0, `UABS_IDX_SCTL1: begin
                rdByte = {access[scSel] ? err_q[scSel] : mbz_q[scSel], sclow_q[scSel]};
            end
            `UABS_IDX_SLADR0:  rdByte = sladr_q[0];
            `UABS_IDX_SLADR1:  rdByte = sladr_q[1];
            `UABS_IDX_SMASK0:  rdByte = smask_q[0];
            `UABS_IDX_SMASK1:  rdByte = smask_q[1];
            `UABS_IDX_GCTL0:   rdByte = gctl_q[0];
            `UABS_IDX_GCTL1:   rdByte = gctl_q[1];
            `UABS_IDX_RELOAD0: rdByte = reload_q[0];
            `UABS_IDX_RELOAD1: rdByte = reload_q[1];
            `UABS_IDX_T2CTL:   rdByte = t2ctl_q;
            `UABS_IDX_PWRCTL:  rdByte = pwr_q;
            default:           mapped = 1'b0;
        endcase
        if (wrEn && mapped) begin
            for (int i = 0; i < 2; i++) begin
                if (idx == (i == 0 ? `UABS_IDX_SCTL0 : `UABS_IDX_SCTL1)) begin
                    sclow_d[i] = dat_i[6:0];
                    if (access[i]) begin
                        err_d[i] = dat_i[`UABS_SC_TOP_BIT];
                    end else begin
                        mbz_d[i] = dat_i[`UABS_SC_TOP_BIT];
                    end
                end
            end
            case (idx)
                `UABS_IDX_SLADR0:  sladr_d[0]  = dat_i[7:0];
                `UABS_IDX_SLADR1:  sladr_d[1]  = dat_i[7:0];
                `UABS_IDX_SMASK0:  smask_d[0]  = dat_i[7:0];
                `UABS_IDX_SMASK1:  smask_d[1]  = dat_i[7:0];
                `UABS_IDX_GCTL0:   gctl_d[0]   = dat_i[7:0];
                `UABS_IDX_GCTL1:   gctl_d[1]   = dat_i[7:0];
                `UABS_IDX_RELOAD0: reload_d[0] = dat_i[7:0];
                `UABS_IDX_RELOAD1: reload_d[1] = dat_i[7:0];
                `UABS_IDX_T2CTL:   t2ctl_d     = dat_i[7:0];
                `UABS_IDX_PWRCTL:  pwr_d       = dat_i[7:0];
                default:           pwr_d       = pwr_q;
            endcase
        end
        // hardware set wins over a clearing write in the same cycle
        for (int i = 0; i < 2; i++) begin
            if (stopBad[i]) begin
                err_d[i] = 1'b1;
            end
        end
        ack_d  = req;
        rdat_d = (req && !we_i) ? {24'h00_0000, rdByte} : 32'h0000_0000;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                sladr_q[i]  <= `UABS_RST_BYTE;
                smask_q[i]  <= `UABS_RST_BYTE;
                gctl_q[i]   <= `UABS_RST_BYTE;
                reload_q[i] <= `UABS_RST_BYTE;
                sclow_q[i]  <= 7'h00;
            end
            err_q   <= 2'b00;
            mbz_q   <= 2'b00;
            t2ctl_q <= `UABS_RST_BYTE;
            pwr_q   <= `UABS_RST_BYTE;
            ack_q   <= 1'b0;
            rdat_q  <= 32'h0000_0000;
        end else begin
            sladr_q  <= sladr_d;
            smask_q  <= smask_d;
            gctl_q   <= gctl_d;
            reload_q <= reload_d;
            sclow_q  <= sclow_d;
            err_q    <= err_d;
            mbz_q    <= mbz_d;
            t2ctl_q  <= t2ctl_d;
            pwr_q    <= pwr_d;
            ack_q    <= ack_d;
            rdat_q   <= rdat_d;
        end
    end

    assign ack_o        = ack_q;
    assign dat_o        = rdat_q;
    assign framingErr0  = err_q[0];
    assign framingErr1  = err_q[1];
    assign modeBitZero0 = mbz_q[0];
    assign modeBitZero1 = mbz_q[1];

    // ------------------------------------------------------------------
    // internal baud generators, one per uart
    // ------------------------------------------------------------------
    logic [2:0]           pre_q  [2];
    logic [2:0]           pre_d  [2];
    uabs_pkg::uabs_byte_t cnt_q  [2];
    uabs_pkg::uabs_byte_t cnt_d  [2];
    logic [4:0]           div_q  [2];
    logic [4:0]           div_d  [2];
    uabs_pkg::uabs_pair_t genTick;
    logic                 dbl;

    assign dbl = pwr_q[`UABS_PC_DBL_BIT];

    for (genvar g = 0; g < 2; g++) begin : gen_baud
        logic run;
        logic speed;
        logic preTick;
        logic ovf;
        logic [4:0] divLast;

        always_comb begin
            run     = gctl_q[g][`UABS_GC_RUN_BIT];
            speed   = gctl_q[g][`UABS_GC_SPEED_BIT];
            divLast = dbl ? `UABS_DIV_LAST_DBL : `UABS_DIV_LAST;
            preTick = speed | (pre_q[g] == `UABS_PRE_LAST);
            ovf     = run & preTick & (cnt_q[g] == `UABS_CNT_TOP);
            pre_d[g] = (!run || preTick) ? 3'h0 : pre_q[g] + 3'h1;
            cnt_d[g] = cnt_q[g];
            if (!run || ovf) begin
                cnt_d[g] = reload_q[g];
            end else if (preTick) begin
                cnt_d[g] = cnt_q[g] + 8'h01;
            end
            div_d[g] = div_q[g];
            if (!run) begin
                div_d[g] = 5'h00;
            end else if (ovf) begin
                div_d[g] = (div_q[g] >= divLast) ? 5'h00 : div_q[g] + 5'h01;
            end
            genTick[g] = ovf & (div_q[g] >= divLast);
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pre_q[g] <= 3'h0;
                cnt_q[g] <= `UABS_RST_BYTE;
                div_q[g] <= 5'h00;
            end else begin
                pre_q[g] <= pre_d[g];
                cnt_q[g] <= cnt_d[g];
                div_q[g] <= div_d[g];
            end
        end
    end

    // ------------------------------------------------------------------
    // clock source selection and address recognition
    // ------------------------------------------------------------------
    logic [3:0] tick_q;
    logic [3:0] tick_d;
    logic [1:0] match_q;
    logic [1:0] match_d;
    logic       t2Tx;
    logic       t2Rx;

    assign t2Tx = t2ctl_q[`UABS_T2_TXSEL_BIT];
    assign t2Rx = t2ctl_q[`UABS_T2_RXSEL_BIT];

    always_comb begin
        tick_d[0] = pickTick(gctl_q[0][`UABS_GC_TXSEL_BIT], t2Tx, genTick[0],
                             timer1Ovf, timer2Ovf);
        tick_d[1] = pickTick(gctl_q[0][`UABS_GC_RXSEL_BIT], t2Rx, genTick[0],
                             timer1Ovf, timer2Ovf);
        tick_d[2] = pickTick(gctl_q[1][`UABS_GC_TXSEL_BIT], t2Tx, genTick[1],
                             timer1Ovf, timer2Ovf);
        tick_d[3] = pickTick(gctl_q[1][`UABS_GC_RXSEL_BIT], t2Rx, genTick[1],
                             timer1Ovf, timer2Ovf);
        match_d[0] = addrHit(rxAddr0, sladr_q[0], smask_q[0]);
        match_d[1] = addrHit(rxAddr1, sladr_q[1], smask_q[1]);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q  <= 4'h0;
            match_q <= 2'b00;
        end else begin
            tick_q  <= tick_d;
            match_q <= match_d;
        end
    end

    assign txTick0    = tick_q[0];
    assign rxTick0    = tick_q[1];
    assign txTick1    = tick_q[2];
    assign rxTick1    = tick_q[3];
    assign addrMatch0 = match_q[0];
    assign addrMatch1 = match_q[1];

endmodule : uabs_baud_addr

// >>> uabs_defs.svh
// constants for the uart baud select and slave address block
// assumes a 32-bit classic wishbone bus, one register per aligned word
`ifndef UABS_DEFS_SVH
`define UABS_DEFS_SVH

// ----------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------
`define UABS_IDX_SCTL0      8'h98
`define UABS_IDX_SCTL1      8'hc0
`define UABS_IDX_SLADR0     8'ha9
`define UABS_IDX_SLADR1     8'haa
`define UABS_IDX_SMASK0     8'hb9
`define UABS_IDX_SMASK1     8'hba
`define UABS_IDX_GCTL0      8'hd0
`define UABS_IDX_GCTL1      8'hd1
`define UABS_IDX_RELOAD0    8'hd2
`define UABS_IDX_RELOAD1    8'hd3
`define UABS_IDX_T2CTL      8'hd4
`define UABS_IDX_PWRCTL     8'hd5

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UABS_SC_TOP_BIT     7
`define UABS_GC_SPEED_BIT   1
`define UABS_GC_RXSEL_BIT   2
`define UABS_GC_TXSEL_BIT   3
`define UABS_GC_RUN_BIT     4
`define UABS_T2_TXSEL_BIT   4
`define UABS_T2_RXSEL_BIT   5
`define UABS_PC_ACC1_BIT    5
`define UABS_PC_ACC0_BIT    6
`define UABS_PC_DBL_BIT     7

// ----------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------
`define UABS_RST_BYTE       8'h00
`define UABS_PRE_LAST       3'h5
`define UABS_CNT_TOP        8'hff
`define UABS_DIV_LAST       5'h1f
`define UABS_DIV_LAST_DBL   5'h0f

`endif

// >>> uabs_pkg.sv
// types shared by the uart baud select and slave address block
// assumes nothing of its surroundings
package uabs_pkg;
    typedef logic [7:0] uabs_byte_t;
    typedef logic [1:0] uabs_pair_t;
endpackage : uabs_pkg

// >>> uabs_serial_node.sv
// far-side serial node: ends frames on either uart lane
// assumes the bench requests a frame with a one-cycle go pulse
`timescale 1ns/100ps

module uabs_serial_node (
    input  wire logic       clk,        // shared clock
    input  wire logic [1:0] go,         // frame ends on lane 0 or 1
    input  wire logic [7:0] frameByte,  // address byte of the frame
    input  wire logic       stopOk,     // stop bit was valid
    output logic      [7:0] rxAddr0,    // lane 0 received byte
    output logic      [7:0] rxAddr1,    // lane 1 received byte
    output logic            rxStopBad0, // lane 0 bad stop pulse
    output logic            rxStopBad1  // lane 1 bad stop pulse
);
    initial begin
        rxAddr0 = 8'h00;
        rxAddr1 = 8'h00;
        rxStopBad0 = 1'b0;
        rxStopBad1 = 1'b0;
    end

    // the received byte stays until the next frame on that lane
    always @(posedge clk) begin
        rxStopBad0 <= go[0] && !stopOk;
        rxStopBad1 <= go[1] && !stopOk;
        if (go[0])
            rxAddr0 <= frameByte;
        if (go[1])
            rxAddr1 <= frameByte;
    end
endmodule : uabs_serial_node

// >>> uabs_baud_addr_assertions.sv
// checker for the baud select and slave address block
// assumes a classic single-cycle bus master
`timescale 1ns/100ps
`include "uabs_defs.svh"

module uabs_baud_addr_assertions (
    input wire logic        clk,         // clock
    input wire logic        arst_n,      // async reset
    input wire logic        cyc_i,       // bus cycle
    input wire logic        stb_i,       // bus strobe
    input wire logic        we_i,        // bus write
    input wire logic [31:0] adr_i,       // bus address
    input wire logic [3:0]  sel_i,       // byte lanes
    input wire logic [31:0] dat_i,       // write data
    input wire logic [31:0] dat_o,       // read data
    input wire logic        ack_o,       // acknowledge
    input wire logic        timer1Ovf,   // timer 1 pulse
    input wire logic        timer2Ovf,   // timer 2 pulse
    input wire logic        rxStopBad0,  // bad stop 0
    input wire logic        rxStopBad1,  // bad stop 1
    input wire logic        txTick0,     // tx tick 0
    input wire logic        rxTick0,     // rx tick 0
    input wire logic        txTick1,     // tx tick 1
    input wire logic        rxTick1,     // rx tick 1
    input wire logic        framingErr0, // error flag 0
    input wire logic        framingErr1  // error flag 1
);
    logic [5:0] selBits_q;
    logic [5:0] selBits_d;
    logic       wrTake;
    logic       clr0;
    logic       clr1;

    assign wrTake = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign clr0 = wrTake && adr_i[9:2] == `UABS_IDX_SCTL0;
    assign clr1 = wrTake && adr_i[9:2] == `UABS_IDX_SCTL1;

    // shadow of timer 2 and generator select bits
    always_comb begin
        selBits_d = selBits_q;
        if (wrTake && adr_i[9:2] == `UABS_IDX_T2CTL)
            selBits_d[1:0] = dat_i[5:4];
        if (wrTake && adr_i[9:2] == `UABS_IDX_GCTL0)
            selBits_d[3:2] = dat_i[3:2];
        if (wrTake && adr_i[9:2] == `UABS_IDX_GCTL1)
            selBits_d[5:4] = dat_i[3:2];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            selBits_q <= 6'h00;
        else
            selBits_q <= selBits_d;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence take_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence answer_s;
        ack_o ##1 !ack_o;
    endsequence

    bus_answer_a: assert property (take_s |=> answer_s)
        else $error("request not answered by one ack pulse");
    idle_data_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    err_set0_a: assert property (rxStopBad0 |=> framingErr0)
        else $error("uart0 error flag not set");
    err_set1_a: assert property (rxStopBad1 |=> framingErr1)
        else $error("uart1 error flag not set");
    err_hold0_a: assert property (framingErr0 && !clr0 |=> framingErr0)
        else $error("uart0 error flag lost");
    err_hold1_a: assert property (framingErr1 && !clr1 |=> framingErr1)
        else $error("uart1 error flag lost");
    tx_src0_a: assert property (!$past(selBits_q[3]) |->
        txTick0 == $past(selBits_q[0] ? timer2Ovf : timer1Ovf))
        else $error("uart0 tx tick from wrong timer");
    rx_src0_a: assert property (!$past(selBits_q[2]) |->
        rxTick0 == $past(selBits_q[1] ? timer2Ovf : timer1Ovf))
        else $error("uart0 rx tick from wrong timer");
    tx_src1_a: assert property (!$past(selBits_q[5]) |->
        txTick1 == $past(selBits_q[0] ? timer2Ovf : timer1Ovf))
        else $error("uart1 tx tick from wrong timer");
    rx_src1_a: assert property (!$past(selBits_q[4]) |->
        rxTick1 == $past(selBits_q[1] ? timer2Ovf : timer1Ovf))
        else $error("uart1 rx tick from wrong timer");
endmodule : uabs_baud_addr_assertions

bind uabs_baud_addr uabs_baud_addr_assertions uabs_baud_addr_assertions_i (
    .clk(clk), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .timer1Ovf(timer1Ovf), .timer2Ovf(timer2Ovf), .rxStopBad0(rxStopBad0),
    .rxStopBad1(rxStopBad1), .txTick0(txTick0), .rxTick0(rxTick0),
    .txTick1(txTick1), .rxTick1(rxTick1), .framingErr0(framingErr0),
    .framingErr1(framingErr1)
);

// >>> uabs_baud_addr_tb.sv
// bench for the baud select and slave address block
// assumes the checker binds itself and the partner ends frames
`timescale 1ns/100ps
`include "uabs_defs.svh"

module uabs_baud_addr_tb;
    logic        clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0000_0000, dat = 32'h0000_0000, datO;
    logic        ack, t1 = 1'b0, t2 = 1'b0, timersOn = 1'b0, stopOk = 1'b1;
    logic [1:0]  go = 2'b00;
    logic [7:0]  frameByte = 8'h00, ra0, ra1;
    logic        bad0, bad1, m0, m1, mb0, mb1, ef0, ef1;
    logic [3:0]  ticks;
    logic [31:0] expQ[$];
    int          numErrors = 0;
    int          nCompared = 0;

    uabs_baud_addr uabs_baud_addr_i (
        .clk(clk), .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hf), .dat_i(dat), .dat_o(datO), .ack_o(ack), .timer1Ovf(t1),
        .timer2Ovf(t2), .rxStopBad0(bad0), .rxStopBad1(bad1), .rxAddr0(ra0),
        .rxAddr1(ra1), .addrMatch0(m0), .addrMatch1(m1), .txTick0(ticks[0]),
        .rxTick0(ticks[1]), .txTick1(ticks[2]), .rxTick1(ticks[3]),
        .modeBitZero0(mb0), .modeBitZero1(mb1), .framingErr0(ef0), .framingErr1(ef1));
    uabs_serial_node uabs_serial_node_i (
        .clk(clk), .go(go), .frameByte(frameByte), .stopOk(stopOk),
        .rxAddr0(ra0), .rxAddr1(ra1), .rxStopBad0(bad0), .rxStopBad1(bad1));

    always #10 clk = ~clk;

    always @(posedge clk) begin
        t1 <= timersOn && ($urandom % 4 == 0);
        t2 <= timersOn && ($urandom % 4 == 0);
    end

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    task automatic chk_bit(input logic g, input logic e);
        compare({31'h0000_0000, g}, {31'h0000_0000, e});
    endtask : chk_bit

    // read data is judged here when the ack appears
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0)
            compare(datO, expQ.pop_front());
    end

    task automatic wb_cycle(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {22'h00_0000, idx, 2'b00};
        dat <= {24'h00_0000, d};
        // only the watchdog ends a wait that never sees ack
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb_cycle

    task automatic wb_read(input logic [7:0] idx, input logic [7:0] e);
        expQ.push_back({24'h00_0000, e});
        wb_cycle(1'b0, idx, 8'h00);
    endtask : wb_read

    task automatic frame(input logic lane, input logic [7:0] b, input logic good);
        @(posedge clk);
        go <= {lane, !lane};
        frameByte <= b;
        stopOk <= good;
        @(posedge clk);
        go <= 2'b00;
        @(posedge clk);
        #1;
    endtask : frame

    task automatic measure(input logic [1:0] t, output int p);
        int n;
        n = 0;
        p = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ticks[t] !== 1'b1 && n < 5000);
        do begin
            @(posedge clk);
            p++;
        end while (ticks[t] !== 1'b1 && p < 5000);
    endtask : measure

    function automatic logic addr_hit(input logic [7:0] rx, sa, mk);
        return ((rx & mk) == (sa & mk)) || ((rx & (sa | mk)) == (sa | mk));
    endfunction : addr_hit

    task automatic results;
        if (numErrors == 0 && nCompared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    initial begin
        repeat (40000) @(posedge clk);
        numErrors++;
        results();
    end

    initial begin
        logic [7:0] idx [4];
        logic [7:0] probe [4];
        logic [7:0] v, sa, mk, rl;
        int         p;
        idx = '{`UABS_IDX_SLADR0, `UABS_IDX_SLADR1, `UABS_IDX_SMASK0, `UABS_IDX_SMASK1};
        probe = '{8'h54, 8'hfb, 8'hf0, 8'h5c};
        void'($urandom(32'h0000_990c));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        compare({30'h0000_0000, m1, m0}, 32'h0000_0003);
        foreach (idx[i]) wb_read(idx[i], 8'h00);
        foreach (idx[i]) begin
            v = 8'($urandom);
            wb_cycle(1'b1, idx[i], v);
            wb_read(idx[i], v);
        end
        wb_cycle(1'b1, 8'h10, 8'h5a);
        wb_read(8'h10, 8'h00);
        for (int l = 0; l < 2; l++) begin
            sa = l ? 8'hf1 : 8'h56;
            mk = l ? 8'hfa : 8'hfc;
            wb_cycle(1'b1, l ? `UABS_IDX_SLADR1 : `UABS_IDX_SLADR0, sa);
            wb_cycle(1'b1, l ? `UABS_IDX_SMASK1 : `UABS_IDX_SMASK0, mk);
            for (int k = 0; k < 10; k++) begin
                v = k < 4 ? probe[k] : 8'($urandom);
                frame(l[0], v, 1'b1);
                chk_bit(l ? m1 : m0, addr_hit(v, sa, mk));
            end
        end
        wb_cycle(1'b1, `UABS_IDX_PWRCTL, 8'h60);
        for (int l = 0; l < 2; l++) begin
            frame(l[0], 8'h33, 1'b0);
            chk_bit(l ? ef1 : ef0, 1'b1);
            frame(l[0], 8'h33, 1'b1);
            chk_bit(l ? ef1 : ef0, 1'b1);
            wb_read(l ? `UABS_IDX_SCTL1 : `UABS_IDX_SCTL0, 8'h80);
            wb_cycle(1'b1, l ? `UABS_IDX_SCTL1 : `UABS_IDX_SCTL0, 8'h00);
            chk_bit(l ? ef1 : ef0, 1'b0);
        end
        wb_cycle(1'b1, `UABS_IDX_PWRCTL, 8'h00);
        wb_cycle(1'b1, `UABS_IDX_SCTL0, 8'h80);
        wb_cycle(1'b1, `UABS_IDX_SCTL1, 8'h80);
        wb_read(`UABS_IDX_SCTL0, 8'h80);
        wb_read(`UABS_IDX_SCTL1, 8'h80);
        compare({28'h000_0000, ef1, ef0, mb1, mb0}, 32'h0000_0003);
        timersOn <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wb_cycle(1'b1, `UABS_IDX_T2CTL, 8'(s * 16));
            repeat (30) @(posedge clk);
        end
        timersOn <= 1'b0;
        // lane, tick direction, speed and doubling all vary across the four runs
        for (int k = 0; k < 4; k++) begin
            rl = 8'hfa + 8'($urandom % 5);
            wb_cycle(1'b1, `UABS_IDX_PWRCTL, {k[1], 7'h00});
            wb_cycle(1'b1, k[0] ? `UABS_IDX_RELOAD1 : `UABS_IDX_RELOAD0, rl);
            wb_cycle(1'b1, k[0] ? `UABS_IDX_GCTL1 : `UABS_IDX_GCTL0,
                     {3'h0, 1'b1, !k[1], k[1], k[0] ^ k[1], 1'b0});
            measure({k[0], k[1]}, p);
            compare(32'(p), 32'((k[0] ^ k[1] ? 1 : 6) * (256 - rl) * (k[1] ? 16 : 32)));
            wb_cycle(1'b1, k[0] ? `UABS_IDX_GCTL1 : `UABS_IDX_GCTL0, 8'h00);
        end
        results();
    end
endmodule : uabs_baud_addr_tb
